// ==== design/dsc_switch_sampler.sv ====
// Configuration switch sampler with Avalon-MM register access
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`include "dsc_cfg.svh"

// Summary of operation
// - Capture eight switches at power-on or reset
// - Keep captured value readable for diagnostics
// - Switch 1 on connects CAN termination
// - Switch 2 on selects firmware download mode
// - Switch 3 forces default addressing parameters
// - Switches 4-6 form offset, 4 is MSB
// - Network fourth octet is base plus offset
// - CAN address is base plus offset times 16
// - Switch changes act only after reset
module dsc_switch_sampler
  import dsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  cfg_switch,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             can_term_en,
  output logic             fw_download_mode,
  output logic             settings_valid,
  output logic      [31:0] net_address,
  output logic      [15:0] net_port,
  output logic      [7:0]  can_node_address
);

  dsc_state_all_t s_q;
  dsc_state_all_t s_d;
  logic [31:0]    rd_mux;
  logic [31:0]    wmask;
  logic [7:0]     octet_sum;
  logic [7:0]     can_sum;

  // Byte-enable mask for software writes of the net and port base parameters
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // Offset arithmetic; the octet wraps modulo 256 like the 8-bit field it feeds
  always_comb
  begin
    octet_sum = s_q.net_base[7:0] + {5'h00, s_q.set.addr_offset};
    can_sum   = s_q.can_base + {1'b0, s_q.set.addr_offset, 4'h0};
  end

  // Read decode; unmapped words read as zero
  always_comb
  begin
    case (avs_address)
      `DSC_REG_RAW:       rd_mux = {24'h000000, s_q.raw};
      `DSC_REG_STATUS:    rd_mux = {24'h000000, s_q.valid, s_q.set.reserved_set,
                                    s_q.set.addr_offset, s_q.set.defaults_forced,
                                    s_q.set.download_mode, s_q.set.term_en};
      `DSC_REG_NET_BASE:  rd_mux = s_q.net_base;
      `DSC_REG_CAN_BASE:  rd_mux = {24'h000000, s_q.can_base};
      `DSC_REG_NET_EFF:   rd_mux = s_q.net_eff;
      `DSC_REG_CAN_EFF:   rd_mux = {24'h000000, s_q.can_eff};
      `DSC_REG_PORT_EFF:  rd_mux = {16'h0000, s_q.port_eff};
      `DSC_REG_PORT_BASE: rd_mux = {16'h0000, s_q.port_base};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    s_d        = s_q;
    s_d.sync1  = cfg_switch;
    s_d.sync2  = s_q.sync1;
    s_d.rvalid = 1'b0;
    case (s_q.state)
      DSC_ST_SETTLE:
      begin
        // Wait until the synchroniser holds post-reset samples only
        if (s_q.settle == `DSC_SETTLE_CYCLES)
        begin
          s_d.state = DSC_ST_LATCH;
        end
        else
        begin
          s_d.settle = s_q.settle + 2'h1;
        end
      end
      DSC_ST_LATCH:
      begin
        s_d.raw                 = s_q.sync2;
        s_d.set.term_en         = s_q.sync2[`DSC_SW_TERM];
        s_d.set.download_mode   = s_q.sync2[`DSC_SW_DOWNLOAD];
        s_d.set.defaults_forced = s_q.sync2[`DSC_SW_DEFAULTS];
        // Switch 4 lands in bit 2 of the offset, switch 6 in bit 0
        s_d.set.addr_offset     = {s_q.sync2[`DSC_SW_OFS_MSB],
                                   s_q.sync2[`DSC_SW_OFS_MSB + 1],
                                   s_q.sync2[`DSC_SW_OFS_LSB]};
        // Reserved switches carry no function; only flagged for diagnosis
        s_d.set.reserved_set    = s_q.sync2[`DSC_SW_RSV_LO] |
                                  s_q.sync2[`DSC_SW_RSV_HI];
        s_d.valid               = 1'b1;
        s_d.state               = DSC_ST_RUN;
      end
      DSC_ST_RUN:
      begin
        // Latched settings held; live switch motion is ignored until reset
        s_d.state = DSC_ST_RUN;
      end
      default:
      begin
        s_d.state = DSC_ST_SETTLE;
      end
    endcase

    // Effective addressing; only address, port and node are overridden.
    // Held at zero until the capture so nothing half-configured is shown.
    if (!s_q.valid)
    begin
      s_d.net_eff  = 32'h00000000;
      s_d.port_eff = 16'h0000;
      s_d.can_eff  = 8'h00;
    end
    else if (s_q.set.defaults_forced)
    begin
      s_d.net_eff  = `DSC_DEF_NET_ADDR;
      s_d.port_eff = `DSC_DEF_PORT;
      s_d.can_eff  = `DSC_DEF_CAN_ADDR;
    end
    else
    begin
      s_d.net_eff  = {s_q.net_base[31:8], octet_sum};
      s_d.port_eff = s_q.port_base;
      s_d.can_eff  = can_sum;
    end

    // Stored base parameters written by firmware; raw and status are read-only
    if (avs_write)
    begin
      case (avs_address)
        `DSC_REG_NET_BASE:
          s_d.net_base = (s_q.net_base & ~wmask) | (avs_writedata & wmask);
        `DSC_REG_CAN_BASE:
          if (avs_byteenable[0])
          begin
            s_d.can_base = avs_writedata[7:0];
          end
        `DSC_REG_PORT_BASE:
          s_d.port_base = (s_q.port_base & ~wmask[15:0]) |
                          (avs_writedata[15:0] & wmask[15:0]);
        default:
        begin
          s_d.net_base = s_q.net_base;
        end
      endcase
    end

    // Read data registered; one wait state per read
    if (avs_read && !s_q.rvalid)
    begin
      s_d.rdata  = rd_mux;
      s_d.rvalid = 1'b1;
    end
  end

  // State register; reset re-arms the capture
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q           <= '0;
      s_q.state     <= DSC_ST_SETTLE;
      s_q.net_base  <= `DSC_RST_NET_BASE;
      s_q.port_base <= `DSC_RST_PORT_BASE;
      s_q.can_base  <= `DSC_RST_CAN_BASE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Reads wait one cycle for registered data; writes complete at once
  assign avs_waitrequest  = avs_read && !s_q.rvalid;
  assign avs_readdata     = s_q.rdata;
  // Outputs stay inactive until the latch has happened
  assign can_term_en      = s_q.set.term_en;
  assign fw_download_mode = s_q.set.download_mode;
  assign settings_valid   = s_q.valid;
  assign net_address      = s_q.net_eff;
  assign net_port         = s_q.port_eff;
  assign can_node_address = s_q.can_eff;

endmodule // dsc_switch_sampler

// ==== shared/dsc_cfg.svh ====
// Constants for the configuration switch sampler
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// Register byte offsets
`define DSC_REG_RAW        5'h00
`define DSC_REG_STATUS     5'h04
`define DSC_REG_NET_BASE   5'h08
`define DSC_REG_CAN_BASE   5'h0c
`define DSC_REG_NET_EFF    5'h10
`define DSC_REG_CAN_EFF    5'h14
`define DSC_REG_PORT_EFF   5'h18
`define DSC_REG_PORT_BASE  5'h1c
// Switch positions (switch n sits at bit n-1)
`define DSC_SW_TERM        0
`define DSC_SW_DOWNLOAD    1
`define DSC_SW_DEFAULTS    2
`define DSC_SW_OFS_MSB     3
`define DSC_SW_OFS_LSB     5
`define DSC_SW_RSV_LO      6
`define DSC_SW_RSV_HI      7
// Forced default addressing: 172.1.1.101, port 50000, node 64
`define DSC_DEF_NET_ADDR   32'hac010165
`define DSC_DEF_PORT       16'hc350
`define DSC_DEF_CAN_ADDR   8'h40
// Reset values of stored base parameters
`define DSC_RST_NET_BASE   32'hc0a80164
`define DSC_RST_PORT_BASE  16'hc350
`define DSC_RST_CAN_BASE   8'h01
// Offset weight for the CAN node address, as a shift of 4 (times 16)
`define DSC_CAN_OFS_SHIFT  4
// Settle cycles after reset release before the synchronised value is latched
`define DSC_SETTLE_CYCLES  2'h2
`endif

// ==== shared/dsc_pkg.sv ====
// Types for the configuration switch sampler
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_ST_SETTLE = 2'b00,
    DSC_ST_LATCH  = 2'b01,
    DSC_ST_RUN    = 2'b10
  } dsc_state_t;

  typedef struct packed {
    logic        term_en;
    logic        download_mode;
    logic        defaults_forced;
    logic [2:0]  addr_offset;
    logic        reserved_set;
  } dsc_settings_t;

  typedef struct packed {
    logic [7:0]    sync1;
    logic [7:0]    sync2;
    logic [7:0]    raw;
    dsc_state_t    state;
    logic [1:0]    settle;
    logic          valid;
    dsc_settings_t set;
    logic [31:0]   net_base;
    logic [15:0]   port_base;
    logic [7:0]    can_base;
    logic [31:0]   net_eff;
    logic [15:0]   port_eff;
    logic [7:0]    can_eff;
    logic [31:0]   rdata;
    logic          rvalid;
  } dsc_state_all_t;
endpackage

// ==== testbench/dsc_switch_bank_model.sv ====
// Behavioural bank of eight static configuration switches
module dsc_switch_bank_model
(
  input  wire logic [7:0] setting,
  output logic      [7:0] cfg_switch
);
  // Plain static levels; switches 7 and 8 stay off unless a test sets them
  assign cfg_switch = setting;
endmodule // dsc_switch_bank_model

// ==== testbench/dsc_switch_sampler_assertions.sv ====
// Port checks for the configuration switch sampler
module dsc_switch_sampler_assertions
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        can_term_en,
  input wire logic        fw_download_mode,
  input wire logic        settings_valid,
  input wire logic [31:0] net_address
);
  // One clock domain, reset cancels every check
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_valid_holds: assert property ($past(settings_valid) |-> settings_valid)
    else $error("settings valid dropped");
  chk_valid_late: assert property ($rose(settings_valid) |-> ($past(rst,4) || $past(rst,5)))
    else $error("capture at wrong moment");
  chk_term_stable: assert property (settings_valid && $past(settings_valid) |-> $stable(can_term_en))
    else $error("termination changed while running");
  chk_dl_stable: assert property (settings_valid && $past(settings_valid) |-> $stable(fw_download_mode))
    else $error("download mode changed while running");
  chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest || !avs_read)
    else $error("read not answered in one cycle");
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_rdata_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_net_idle: assert property (!settings_valid |-> net_address == 32'h0)
    else $error("address shown before capture");
endmodule // dsc_switch_sampler_assertions

bind dsc_switch_sampler dsc_switch_sampler_assertions i_chk (.*);

// ==== testbench/tb_dsc_switch_sampler.sv ====
// Self-checking bench for the configuration switch sampler
`include "dsc_cfg.svh"
module tb_dsc_switch_sampler;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [7:0]  sw_set = 8'h00;
  logic        avs_waitrequest, can_term_en, fw_download_mode, settings_valid;
  logic [31:0] avs_readdata, net_address, q;
  logic [7:0]  cfg_switch, can_node_address;
  logic [15:0] net_port;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  dsc_switch_bank_model i_sw (.setting(sw_set), .cfg_switch(cfg_switch));
  dsc_switch_sampler i_dut (.*);
  // Clock and a hang guard sized well above the whole sequence
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bus cycle: request held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic restart(input logic [7:0] s);
    sw_set <= s;
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 20 && settings_valid !== 1'b1; i++)
      @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic outs(input logic t, input logic d, input logic [31:0] n,
                      input logic [15:0] p, input logic [7:0] c);
    check("valid", 32'(settings_valid), 32'h1);
    check("term", 32'(can_term_en), 32'(t));
    check("download", 32'(fw_download_mode), 32'(d));
    check("net", net_address, n);
    check("port", 32'(net_port), 32'(p));
    check("can", 32'(can_node_address), 32'(c));
  endtask
  task automatic stop_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Offset 5 with termination, then base writes with wrapping sums
  initial
  begin
    restart(8'h29);
    outs(1'b1, 1'b0, 32'hc0a80169, 16'hc350, 8'h51);
    bus(1'b0, `DSC_REG_RAW, 32'h0);
    check("raw", q, 32'h29);
    bus(1'b0, `DSC_REG_STATUS, 32'h0);
    check("status", q, 32'ha9);
    bus(1'b1, `DSC_REG_RAW, 32'h0);
    bus(1'b0, `DSC_REG_RAW, 32'h0);
    check("raw kept", q, 32'h29);
    bus(1'b1, `DSC_REG_NET_BASE, 32'h0a0000fe);
    bus(1'b1, `DSC_REG_CAN_BASE, 32'hf0);
    bus(1'b1, `DSC_REG_PORT_BASE, 32'h1234);
    sw_set <= 8'hd6;
    repeat (3) @(posedge ref_clk);
    outs(1'b1, 1'b0, 32'h0a000003, 16'h1234, 8'h40);
    bus(1'b0, `DSC_REG_NET_BASE, 32'h0);
    check("net base", q, 32'h0a0000fe);
    // Forced defaults with download and a reserved switch on
    restart(8'h46);
    bus(1'b1, `DSC_REG_NET_BASE, 32'h0a000001);
    outs(1'b0, 1'b1, 32'hac010165, 16'hc350, 8'h40);
    bus(1'b0, `DSC_REG_STATUS, 32'h0);
    check("status", q, 32'hc6);
    sw_set <= 8'h00;
    repeat (3) @(posedge ref_clk);
    outs(1'b0, 1'b1, 32'hac010165, 16'hc350, 8'h40);
    stop_test();
  end
endmodule // tb_dsc_switch_sampler
